// ### rtl/pam_pkg.sv
// Shared constants, request and state types of the port pin block.
package pam_pkg;

    // Port geometry: three 8-bit ports, flattened pin index is port*8+bit.
    localparam int PORT_W   = 8;
    localparam int PORT_CNT = 3;
    localparam int PIN_CNT  = 24;

    // Port numbers seen on the request port.
    localparam logic [1:0] PORT_CONV = 2'h0;
    localparam logic [1:0] PORT_DBG  = 2'h1;
    localparam logic [1:0] PORT_OSC  = 2'h2;

    // Flattened pin positions of the shared oscillator and debug pins.
    localparam int PIN_MAIN_IN  = 17;
    localparam int PIN_MAIN_OUT = 18;
    localparam int PIN_SUB_IN   = 19;
    localparam int PIN_SUB_OUT  = 20;
    localparam int PIN_DBG_A    = 9;
    localparam int PIN_DBG_B    = 10;

    // Field positions inside the clock operation mode register.
    localparam int MODE_MAIN_EXT = 7;
    localparam int MODE_MAIN_SEL = 6;
    localparam int MODE_SUB_EXT  = 5;
    localparam int MODE_SUB_SEL  = 4;

    // Values after reset.
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST   = 8'hff;
    localparam logic [3:0] CFG_RST   = 4'h0;
    localparam logic [2:0] CHAN_RST  = 3'h0;
    localparam logic [7:0] MODE_RST  = 8'h00;

    // Configuration code that makes all eight converter pins digital.
    localparam logic [3:0] CFG_ALL_DIGITAL = 4'h8;

    // Request operations, one-hot.
    typedef enum logic [7:0] {
        OP_WR_DATA = 8'h01,
        OP_RD_DATA = 8'h02,
        OP_BIT_SET = 8'h04,
        OP_BIT_CLR = 8'h08,
        OP_WR_DIR  = 8'h10,
        OP_WR_CFG  = 8'h20,
        OP_WR_CHAN = 8'h40,
        OP_WR_MODE = 8'h80
    } pam_op_e;

    typedef struct packed {
        logic       valid;
        pam_op_e    op;
        logic [1:0] port;
        logic [2:0] bit_idx;
        logic [7:0] data;
    } pam_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } pam_rsp_s;

    typedef struct packed {
        logic s1;
        logic s2;
    } pam_sync_s;

    typedef struct packed {
        logic [PORT_CNT-1:0][PORT_W-1:0] latch;
        logic [PORT_CNT-1:0][PORT_W-1:0] dir;
        logic [3:0]                      cfg;
        logic [2:0]                      chan;
        logic [7:0]                      mode;
        logic [PIN_CNT-1:0]              pin_out;
        logic [PIN_CNT-1:0]              pin_oe;
        pam_rsp_s                        rsp;
        logic [PORT_W-1:0]               adc_select;
        logic                            adc_sample;
        logic [3:0]                      dbg_mode;
    } pam_state_s;

endpackage

// ### rtl/pam_pin_sync.sv
// Two-stage synchroniser for one pin input.
`timescale 1ns/10ps
module pam_pin_sync #(
    parameter logic RST_LEVEL = 1'b0
) (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic pad_in,
    output logic      level
);

    pam_pkg::pam_sync_s st_reg;
    pam_pkg::pam_sync_s st_next;

    // The first stage feeds only the second stage.
    always_comb begin
        st_next = st_reg;
        if (clk_en) begin
            st_next.s1 = pad_in;
            st_next.s2 = st_reg.s1;
        end
    end

    // State register with asynchronous reset to a constant.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '{s1: RST_LEVEL, s2: RST_LEVEL};
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.s2;

endmodule

// ### rtl/pam_port_block.sv
// Port pins with direction, latches, converter, oscillator and debug sharing.
`timescale 1ns/10ps
// Operation
// RL1: Analog, input and channel-selected converter pin is the sampled input.
// RL2: Analog input pin not selected stays analog, undriven, not converted.
// RL3: Converter pin role follows pin config, channel select and direction.
// RL4: Alternate inputs need direction bit 1; latch then ignored.
// RL5: Alternate outputs need direction 0, latch 0; serial clocks latch 1.
// RL6: Software selects oscillator mode before pins serve as clock pins.
// RL7: Clock mode register resets to zero; oscillator pins are ports.
// RL8: Oscillator-owned pins ignore direction bit and output latch.
// RL9: With debug active, four pins become debug mode-setting inputs.
// RL10: Input-direction bit: write updates latch, read returns pin level.
// RL11: Bit instruction reads whole byte, changes one bit, writes byte.
// RL12: Bit write-back may copy input pin levels into their latches.
// RL13: Software rewrites latch when switching a port to output.
// RL14: Latches clear on reset and otherwise hold the last write.
// RL15: Output-direction bit reads return the latch unchanged.
// RL16: Digital input shows pin level; digital output drives the latch.
module pam_port_block (
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  clk_en,
    input  pam_pkg::pam_req_s          req,
    input  wire logic                  debug_active,
    input  wire logic [23:0]           pin_in,
    output logic      [23:0]           pin_out,
    output logic      [23:0]           pin_oe,
    output pam_pkg::pam_rsp_s          rsp,
    output logic      [7:0]            adc_select,
    output logic                       adc_sample,
    output logic      [7:0]            clock_mode,
    output logic      [3:0]            debug_mode_set_pin
);

    pam_pkg::pam_state_s st;
    pam_pkg::pam_state_s st_next;

    logic [23:0]     pin_sync;
    logic [7:0]      analog;
    logic [23:0]     blocked;
    logic [2:0][7:0] rd_view;

    // Every pin input passes two flip-flops before use.
    for (genvar g = 0; g < pam_pkg::PIN_CNT; g++) begin : g_sync
        pam_pin_sync #(
            .RST_LEVEL (1'b0)
        ) u_sync (
            .ref_clk (ref_clk),
            .sys_rst (sys_rst),
            .clk_en  (clk_en),
            .pad_in  (pin_in[g]),
            .level   (pin_sync[g])
        );
    end

    // Classify each pin and form the byte view that a read returns.
    always_comb begin
        analog  = '0;
        blocked = '0;
        for (int i = 0; i < 8; i++) begin
            analog[i] = (st.cfg <= pam_pkg::CFG_ALL_DIGITAL)
                        && (4'(i) >= st.cfg);                      // [RL3]
        end
        blocked[7:0] = analog;                                     // [RL2]
        // Oscillator modes take pins away from the port.
        blocked[pam_pkg::PIN_MAIN_IN]  = st.mode[pam_pkg::MODE_MAIN_SEL]
            && !st.mode[pam_pkg::MODE_MAIN_EXT];                   // [RL8]
        blocked[pam_pkg::PIN_MAIN_OUT] = st.mode[pam_pkg::MODE_MAIN_SEL];
        blocked[pam_pkg::PIN_SUB_IN]   = st.mode[pam_pkg::MODE_SUB_SEL]
            && !st.mode[pam_pkg::MODE_SUB_EXT];
        blocked[pam_pkg::PIN_SUB_OUT]  = st.mode[pam_pkg::MODE_SUB_SEL];
        // Debug use overrides the normal role of four pins.
        if (debug_active) begin                                    // [RL9]
            blocked[pam_pkg::PIN_MAIN_IN]  = 1'b1;
            blocked[pam_pkg::PIN_MAIN_OUT] = 1'b1;
            blocked[pam_pkg::PIN_DBG_A]    = 1'b1;
            blocked[pam_pkg::PIN_DBG_B]    = 1'b1;
        end
        for (int p = 0; p < pam_pkg::PORT_CNT; p++) begin
            for (int b = 0; b < pam_pkg::PORT_W; b++) begin
                if (st.dir[p][b]) begin
                    rd_view[p][b] = blocked[p*8+b] ? 1'b0
                                    : pin_sync[p*8+b];             // [RL10]
                end else begin
                    rd_view[p][b] = st.latch[p][b];                // [RL15]
                end
            end
        end
    end

    // Request decode, register update and registered pin outputs.
    always_comb begin
        logic [7:0] cur;
        logic       hit;
        cur     = 8'h00;
        hit     = req.port <= pam_pkg::PORT_OSC;
        st_next = st;
        st_next.rsp.valid = 1'b0;
        if (hit) begin
            cur = rd_view[req.port];
        end
        if (req.valid) begin
            unique case (req.op)
                pam_pkg::OP_WR_DATA: begin
                    if (hit) begin
                        st_next.latch[req.port] = req.data;        // [RL10]
                    end
                end
                pam_pkg::OP_RD_DATA: begin
                    st_next.rsp.valid = 1'b1;
                    st_next.rsp.data  = cur;                       // [RL15]
                end
                pam_pkg::OP_BIT_SET, pam_pkg::OP_BIT_CLR: begin
                    // Whole byte is read, one bit changed, byte written.
                    cur[req.bit_idx] = (req.op == pam_pkg::OP_BIT_SET);
                    if (hit) begin
                        st_next.latch[req.port] = cur;     // [RL11] [RL12]
                    end
                end
                pam_pkg::OP_WR_DIR: begin
                    if (hit) begin
                        st_next.dir[req.port] = req.data;
                    end
                end
                pam_pkg::OP_WR_CFG:  st_next.cfg  = req.data[3:0];
                pam_pkg::OP_WR_CHAN: st_next.chan = req.data[2:0];
                pam_pkg::OP_WR_MODE: st_next.mode = req.data;
                default: ;
            endcase
        end
        for (int i = 0; i < pam_pkg::PIN_CNT; i++) begin
            st_next.pin_out[i] = st_next.latch[i/8][i%8];          // [RL16]
            st_next.pin_oe[i]  = !st_next.dir[i/8][i%8]
                                 && !blocked[i];           // [RL1] [RL8]
        end
        for (int i = 0; i < 8; i++) begin
            st_next.adc_select[i] = analog[i] && st.dir[0][i]
                                    && (st.chan == 3'(i));         // [RL1]
        end
        st_next.adc_sample = |st_next.adc_select;
        st_next.dbg_mode = debug_active ? {pin_sync[pam_pkg::PIN_DBG_B],
            pin_sync[pam_pkg::PIN_DBG_A], pin_sync[pam_pkg::PIN_MAIN_OUT],
            pin_sync[pam_pkg::PIN_MAIN_IN]} : 4'h0;                // [RL9]
        if (!clk_en) begin
            st_next = st;
        end
    end

    // State register; latches and clock mode clear on reset.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st            <= '0;
            st.latch      <= {3{pam_pkg::LATCH_RST}};              // [RL14]
            st.dir        <= {3{pam_pkg::DIR_RST}};
            st.cfg        <= pam_pkg::CFG_RST;
            st.chan       <= pam_pkg::CHAN_RST;
            st.mode       <= pam_pkg::MODE_RST;                    // [RL7]
        end else begin
            st <= st_next;
        end
    end

    assign pin_out            = st.pin_out;
    assign pin_oe             = st.pin_oe;
    assign rsp                = st.rsp;
    assign adc_select         = st.adc_select;
    assign adc_sample         = st.adc_sample;
    assign clock_mode         = st.mode;
    assign debug_mode_set_pin = st.dbg_mode;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    logic [7:0] exp_rmw;
    always_comb begin
        exp_rmw = (req.port <= pam_pkg::PORT_OSC) ? rd_view[req.port] : 8'h00;
        exp_rmw[req.bit_idx] = (req.op == pam_pkg::OP_BIT_SET);
    end

    a_latch_hold: assert property (                                // [RL14]
        !clk_en || !req.valid |=> $stable(st.latch))
        else $error("Port latch changed without a write.");
    a_rd_output: assert property (                                 // [RL15]
        clk_en && req.valid && req.op == pam_pkg::OP_RD_DATA
        && req.port == pam_pkg::PORT_DBG && !st.dir[1][0]
        |=> rsp.valid && rsp.data[0] == $past(st.latch[1][0]))
        else $error("Output bit read did not return latch.");
    a_rd_input: assert property (                                  // [RL10]
        clk_en && req.valid && req.op == pam_pkg::OP_RD_DATA
        && req.port == pam_pkg::PORT_DBG && st.dir[1][7]
        |=> rsp.data[7] == $past(pin_sync[15]))
        else $error("Input bit read did not return pin level.");
    a_bit_rmw: assert property (                           // [RL11] [RL12]
        clk_en && req.valid && req.port == pam_pkg::PORT_DBG
        && (req.op == pam_pkg::OP_BIT_SET || req.op == pam_pkg::OP_BIT_CLR)
        |=> st.latch[1] == $past(exp_rmw))
        else $error("Bit operation write-back wrong.");
    a_analog_undriven: assert property (                   // [RL1] [RL2]
        clk_en && st.cfg == 4'h0 |=> pin_oe[7:0] == 8'h00)
        else $error("Analog pin was driven.");
    a_conv_sample: assert property (                               // [RL1]
        clk_en && st.cfg == 4'h0 && st.dir[0][st.chan]
        |=> adc_sample ##0 adc_select[$past(st.chan)])
        else $error("Selected analog input not sampled.");
    a_digital_drive: assert property (                             // [RL16]
        clk_en ##1 !st.dir[2][7] |-> pin_oe[23] && pin_out[23] == st.latch[2][7])
        else $error("Digital output does not drive latch.");
    // Ownership is taken from the mode held before the edge, so the drive
    // enable drops one edge after the mode bit is seen set.
    a_osc_owned: assert property (                                 // [RL8]
        clk_en && st.mode[pam_pkg::MODE_MAIN_SEL] |=> !pin_oe[18])
        else $error("Oscillator pin driven as port.");
    a_debug_pins: assert property (                                // [RL9]
        clk_en && debug_active |=> !pin_oe[9] && !pin_oe[10]
        && debug_mode_set_pin == {$past(pin_sync[10]), $past(pin_sync[9]),
        $past(pin_sync[18]), $past(pin_sync[17])})
        else $error("Debug pins not taken over.");
    a_mode_reset: assert property (                        // [RL7] [RL14]
        @(posedge ref_clk) disable iff (1'b0)
        $fell(sys_rst) |-> clock_mode == 8'h00 && st.latch == '0)
        else $error("Clock mode or latch not cleared by reset.");

endmodule

// ### testbench/pam_pin_model.sv
// Model of the package pins: driven pins loop back, others show outside levels.
`timescale 1ns/10ps
module pam_pin_model (
    input  wire logic [23:0] pin_out,
    input  wire logic [23:0] pin_oe,
    input  wire logic [23:0] ext_level,
    output logic      [23:0] pin_in
);
    // A driven pin reads back its own drive; an undriven one reads the board.
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
        end
    end
endmodule

// ### testbench/port_alternate_function_rmw_tb_top.sv
// Self-checking bench for the port pin block.
`timescale 1ns/10ps
module port_alternate_function_rmw_tb_top;
    logic              ref_clk;
    logic              sys_rst;
    logic              clk_en;
    logic              debug_active;
    pam_pkg::pam_req_s req;
    pam_pkg::pam_rsp_s rsp;
    logic [23:0]       pin_in;
    logic [23:0]       pin_out;
    logic [23:0]       pin_oe;
    logic [23:0]       ext_lvl;
    logic [7:0]        adc_select;
    logic              adc_sample;
    logic [7:0]        clock_mode;
    logic [3:0]        dbg_set;
    int                n_errors;
    int                total_checks;
    int                cycles;
    logic [7:0]        mode_tab [3];
    logic [7:0]        oe_tab [3];

    pam_port_block dut (
        .ref_clk            (ref_clk),
        .sys_rst            (sys_rst),
        .clk_en             (clk_en),
        .req                (req),
        .debug_active       (debug_active),
        .pin_in             (pin_in),
        .pin_out            (pin_out),
        .pin_oe             (pin_oe),
        .rsp                (rsp),
        .adc_select         (adc_select),
        .adc_sample         (adc_sample),
        .clock_mode         (clock_mode),
        .debug_mode_set_pin (dbg_set)
    );

    pam_pin_model pins (
        .pin_out   (pin_out),
        .pin_oe    (pin_oe),
        .ext_level (ext_lvl),
        .pin_in    (pin_in)
    );

    // Free-running 50 ns clock.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Compares one value and reports a difference.
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic close_out;
        if (n_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Issues one request for a single cycle, returning at the falling edge that ends it.
    task automatic do_req(input pam_pkg::pam_op_e op, input logic [1:0] port,
                          input logic [2:0] idx, input logic [7:0] data);
        @(negedge ref_clk);
        req.valid   = 1'b1;
        req.op      = op;
        req.port    = port;
        req.bit_idx = idx;
        req.data    = data;
        @(negedge ref_clk);
        req.valid = 1'b0;
    endtask

    // Reads one port byte; the answer stands in the cycle after the request.
    task automatic rd(input logic [1:0] port, input logic [7:0] exp);
        do_req(pam_pkg::OP_RD_DATA, port, 3'h0, 8'h00);
        chk("rsp.valid", rsp.valid, 1'b1);
        chk("rsp.data", rsp.data, exp);
    endtask

    // Waits a number of clock cycles, ending at a falling edge.
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Cuts a hung run short.
    initial begin
        cycles = 0;
        forever begin
            @(posedge ref_clk);
            cycles++;
            if (cycles >= 3000) begin
                n_errors++;
                close_out();
            end
        end
    end

    // Main sequence.
    initial begin
        n_errors     = 0;
        total_checks = 0;
        sys_rst      = 1'b1;
        clk_en       = 1'b1;
        debug_active = 1'b0;
        req          = '0;
        ext_lvl      = {8'h00, 8'ha5, 8'h5a};
        mode_tab     = '{8'h40, 8'hf0, 8'h50};
        oe_tab       = '{8'hf9, 8'heb, 8'he1};
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        idle(3);
        // Reset state: ports, mode register and converter pin 0 selected.
        chk("clock_mode", clock_mode, 8'h00);
        chk("pin_out", pin_out, 32'h0);
        chk("adc_select", adc_select, 8'h01);
        rd(2'h1, 8'ha5);
        rd(2'h0, 8'h00);
        // Input-direction write lands in the latch only.
        do_req(pam_pkg::OP_WR_DATA, 2'h1, 3'h0, 8'h3c);
        chk("pin_out p1", pin_out[15:8], 8'h3c);
        chk("pin_oe p1", pin_oe[15:8], 8'h00);
        rd(2'h1, 8'ha5);
        // Latch rewritten before bit 0 turns output.
        ext_lvl[15:8] = 8'hf0;
        do_req(pam_pkg::OP_WR_DATA, 2'h1, 3'h0, 8'h00);
        do_req(pam_pkg::OP_WR_DIR, 2'h1, 3'h0, 8'hfe);
        idle(3);
        chk("pin_oe p1", pin_oe[15:8], 8'h01);
        // Bit set copies input pin levels into their latches.
        do_req(pam_pkg::OP_BIT_SET, 2'h1, 3'h0, 8'h00);
        chk("pin_out p1", pin_out[15:8], 8'hf1);
        rd(2'h1, 8'hf1);
        do_req(pam_pkg::OP_BIT_CLR, 2'h1, 3'h4, 8'h00);
        chk("pin_out p1", pin_out[15:8], 8'he1);
        do_req(pam_pkg::OP_WR_DIR, 2'h1, 3'h0, 8'h00);
        rd(2'h1, 8'he1);
        // Converter pins: channel select, configuration and direction.
        // The converter select follows a setting write one edge later.
        do_req(pam_pkg::OP_WR_CHAN, 2'h0, 3'h0, 8'h05);
        idle(1);
        chk("adc_select", adc_select, 8'h20);
        chk("adc_sample", adc_sample, 1'b1);
        do_req(pam_pkg::OP_WR_CFG, 2'h0, 3'h0, 8'h08);
        idle(1);
        chk("adc_select", adc_select, 8'h00);
        chk("adc_sample", adc_sample, 1'b0);
        rd(2'h0, 8'h5a);
        do_req(pam_pkg::OP_WR_CFG, 2'h0, 3'h0, 8'h04);
        idle(1);
        chk("adc_select", adc_select, 8'h20);
        rd(2'h0, 8'h0a);
        do_req(pam_pkg::OP_WR_CHAN, 2'h0, 3'h0, 8'h02);
        idle(1);
        chk("adc_select", adc_select, 8'h00);
        do_req(pam_pkg::OP_WR_DIR, 2'h0, 3'h0, 8'h00);
        chk("pin_oe p0", pin_oe[7:0], 8'h0f);
        // Oscillator port driven, then handed to three clock modes in turn.
        do_req(pam_pkg::OP_WR_DATA, 2'h2, 3'h0, 8'hff);
        do_req(pam_pkg::OP_WR_DIR, 2'h2, 3'h0, 8'h00);
        chk("pin_oe p2", pin_oe[23:16], 8'hff);
        for (int i = 0; i < 3; i++) begin
            do_req(pam_pkg::OP_WR_MODE, 2'h2, 3'h0, mode_tab[i]);
            chk("clock_mode", clock_mode, mode_tab[i]);
            // Pin ownership follows the new mode one edge later.
            idle(1);
            chk("pin_oe p2", pin_oe[23:16], oe_tab[i]);
        end
        do_req(pam_pkg::OP_WR_MODE, 2'h2, 3'h0, 8'h00);
        // Debug use takes over the four mode-setting pins.
        ext_lvl[23:16] = 8'h02;
        ext_lvl[15:8]  = 8'h02;
        debug_active   = 1'b1;
        idle(5);
        chk("debug pins", dbg_set, 4'h5);
        chk("pin_oe dbg", {pin_oe[18:17], pin_oe[10:9]}, 4'h0);
        debug_active = 1'b0;
        idle(2);
        chk("debug pins", dbg_set, 4'h0);
        close_out();
    end
endmodule
